/* File: logic/timer_slave_ctrl.sv */
`timescale 1ns/1ps

// What this block does
// - Polarity bit 0 passes the external trigger as is, 1 inverts it.
// - Clock mode 2 enable counts on active edges of the filtered trigger.
// - Clock mode 2 equals clock mode 1 on the filtered trigger; it wins.
// - External trigger predivider: none, by 2, by 4, by 8.
// - Filter accepts a new level after N equal samples at coded rates.
// - Master/slave sync delays the effect of a trigger input event.
// - Trigger source picks internal triggers, input 1 edge, inputs, external.
// - Slave mode off: counter runs on internal clock when enabled.
// - Encoder modes count up or down on input edges per other level.
// - Reset mode: trigger rising edge reinitialises counter and updates.
// - Gated mode: counter runs only while trigger is high, no reset.
// - Trigger mode: rising edge starts the counter without reset.
// - External clock mode 1: trigger rising edges clock the counter.
// - Internal trigger i of timer k comes from timer (k+i+1) mod 5.
// - Separate DMA enables in bits 14 to 8, interrupt enables 7 to 0.
// - Overcapture flag sets on capture while event flag set; write 0 clears.
// - Break flag sets on active break; clear only while break inactive.
// - Trigger flag sets on trigger event, both edges in gated mode.
// - Switch flag sets when preloaded control bits become active.
module timer_slave_ctrl
	import tsm_pkg::*;
#(
	parameter int TIMER_INDEX = 0
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] clkDivSel,
	input wire logic extTriggerPin,
	input wire logic in1EdgePulse,
	input wire logic in1Filtered,
	input wire logic in2Filtered,
	input wire logic [NUM_TIMERS-1:0] siblingTrigOut,
	input wire logic countEnable,
	input wire logic breakActive,
	input wire logic updateEvent,
	input wire logic [NUM_CHANNELS-1:0] chanEvent,
	input wire logic [NUM_CHANNELS-1:0] chanIsInput,
	input wire logic switchEvent,
	output logic countTick,
	output logic countDown,
	output logic counterReinit,
	output logic updateRequest,
	output logic countStart,
	output logic trigEvent,
	output logic extTrigFiltered,
	output logic slaveTriggerIn,
	output logic irq,
	output logic [6:0] dmaReq
);

	// Sibling whose master trigger feeds internal trigger i of this timer.
	function automatic int ring_pick(input int k, input int i);
		return (k + i + 1) % NUM_TIMERS;
	endfunction

	logic [15:0] slaveModeControl;
	logic [15:0] irqDmaEnable;
	logic [15:0] eventStatus;

	// Register fields by name.
	logic extTrigPolarity;
	logic extClk2Enable;
	logic [1:0] extTrigPrediv;
	logic [3:0] extTrigFilter;
	logic masterSlaveSync;
	trig_src_t trigSource;
	slave_mode_t slaveModeSel;

	assign extTrigPolarity = slaveModeControl[SMC_POL_BIT];
	assign extClk2Enable = slaveModeControl[SMC_ECE_BIT];
	assign extTrigPrediv = slaveModeControl[SMC_PREDIV_LSB +: 2];
	assign extTrigFilter = slaveModeControl[SMC_FILT_LSB +: 4];
	assign masterSlaveSync = slaveModeControl[SMC_MSM_BIT];
	assign trigSource = trig_src_t'(slaveModeControl[SMC_TS_LSB +: 3]);
	assign slaveModeSel = slave_mode_t'(slaveModeControl[SMC_SMS_LSB +: 3]);

	// APB decode; the slave never inserts wait states.
	logic hitSmc;
	logic hitIde;
	logic hitEvs;
	logic hitAny;
	logic wrAccess;
	logic rdSetup;
	logic [15:0] readMux;

	// Unmapped addresses answer with an error and read as zero; writes
	// to them are dropped.
	assign hitSmc = (paddr == OFS_SLAVE_MODE_CONTROL);
	assign hitIde = (paddr == OFS_IRQ_DMA_ENABLE);
	assign hitEvs = (paddr == OFS_EVENT_STATUS);
	assign hitAny = hitSmc | hitIde | hitEvs;
	assign wrAccess = psel & penable & pwrite;
	assign rdSetup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hitAny;
	assign readMux = hitSmc ? slaveModeControl :
		hitIde ? irqDmaEnable :
		hitEvs ? eventStatus : 16'h0000;

	// External trigger path: polarity, predivider, then filter.
	logic etrConditioned;
	logic etrPrescaled;
	logic dtsTick;
	logic [1:0] dtsCount;
	logic [1:0] dtsMask;

	assign etrConditioned = extTriggerPin ^ extTrigPolarity;

	// The divider keeps counting through every ratio, so changing the
	// ratio while clock mode 2 is on may show one stray edge; software
	// should settle the ratio before it sets the mode 2 enable.
	ext_trig_prescaler prescaler (
		.mclk(mclk),
		.rstn(rstn),
		.trigIn(etrConditioned),
		.prediv(extTrigPrediv),
		.prescaled(etrPrescaled)
	);

	// Reserved ratio code 3 falls back to divide by four.
	// The dts tick is a one-cycle enable, never a second clock.
	assign dtsMask = (clkDivSel == 2'h0) ? 2'h0 :
		(clkDivSel == 2'h1) ? 2'h1 : 2'h3;
	assign dtsTick = ((dtsCount & dtsMask) == 2'h0);

	ext_trig_filter filter (
		.mclk(mclk),
		.rstn(rstn),
		.sampleIn(etrPrescaled),
		.code(extTrigFilter),
		.dtsTick(dtsTick),
		.filtered(extTrigFiltered)
	);

	// Internal trigger ring among the sibling timers.
	logic [3:0] internalTrig;
	for (genvar i = 0; i < 4; i++) begin : g_ring
		assign internalTrig[i] =
			siblingTrigOut[ring_pick(TIMER_INDEX, i)];
	end

	// Trigger source selection, indexed by the source code.
	logic [7:0] trigSources;
	logic trigRaw;
	logic trigDelayed;
	logic trigPrev;
	logic trigRise;
	logic trigFall;

	assign trigSources = {extTrigFiltered, in2Filtered, in1Filtered,
		in1EdgePulse, internalTrig};
	assign trigRaw = trigSources[trigSource];
	// One stage of delay lets our own master trigger reach slaves in step.
	assign slaveTriggerIn = masterSlaveSync ? trigDelayed : trigRaw;
	assign trigRise = slaveTriggerIn & ~trigPrev;
	assign trigFall = ~slaveTriggerIn & trigPrev;

	// Edge detection on the filtered external trigger and encoder inputs.
	logic etrfPrev;
	logic etrfRise;
	logic in1Prev;
	logic in2Prev;
	logic in1Edge;
	logic in2Edge;

	assign etrfRise = extTrigFiltered & ~etrfPrev;
	assign in1Edge = in1Filtered ^ in1Prev;
	assign in2Edge = in2Filtered ^ in2Prev;

	// Encoder decoding: the edge of one input, the level of the other.
	logic isEncoder;
	logic encOnIn1;
	logic encOnIn2;
	logic encTick;
	logic encDown;

	assign isEncoder = (slaveModeSel == SMS_ENC1) ||
		(slaveModeSel == SMS_ENC2) || (slaveModeSel == SMS_ENC3);
	assign encOnIn1 = in1Edge && ((slaveModeSel == SMS_ENC1) ||
		(slaveModeSel == SMS_ENC3));
	assign encOnIn2 = in2Edge && ((slaveModeSel == SMS_ENC2) ||
		(slaveModeSel == SMS_ENC3));
	assign encTick = encOnIn1 | encOnIn2;
	assign encDown = encOnIn1 ? (in1Filtered == in2Filtered) :
		(in1Filtered != in2Filtered);

	// Counter clock source. Clock mode 2 overrides mode 1 and the internal
	// clock; software keeps the external source out of the trigger path
	// whenever mode 2 is combined with another slave mode.
	logic baseTick;
	logic gateOpen;
	logic next_countTick;

	assign baseTick = extClk2Enable ? etrfRise :
		(slaveModeSel == SMS_EXTCLK1) ? trigRise :
		1'b1;
	assign gateOpen = (slaveModeSel != SMS_GATED) || slaveTriggerIn;
	assign next_countTick = countEnable &
		(isEncoder ? encTick : (baseTick & gateOpen));

	// Trigger-driven counter controls and the trigger event itself.
	logic next_reinit;
	logic next_start;
	logic next_trigEvent;

	assign next_reinit = (slaveModeSel == SMS_RESET) && trigRise;
	assign next_start = (slaveModeSel == SMS_TRIGGER) && trigRise;
	assign next_trigEvent = (slaveModeSel != SMS_OFF) &&
		((slaveModeSel == SMS_GATED) ? (trigRise | trigFall) :
		trigRise);

	// Status flags: hardware set wins over a software clear in one cycle.
	logic [15:0] flagSet;
	logic [15:0] flagClr;
	logic [15:0] next_eventStatus;
	logic [3:0] overCapture;

	assign overCapture = chanEvent & chanIsInput &
		eventStatus[EVS_CHAN_LSB +: NUM_CHANNELS];

	always_comb begin
		flagSet = 16'h0000;
		flagSet[EVS_UPDATE_BIT] = updateEvent;
		flagSet[EVS_CHAN_LSB +: NUM_CHANNELS] = chanEvent;
		flagSet[EVS_SWITCH_BIT] = switchEvent;
		flagSet[EVS_TRIG_BIT] = next_trigEvent;
		flagSet[EVS_BREAK_BIT] = breakActive;
		flagSet[EVS_OVC_LSB +: NUM_CHANNELS] = overCapture;
	end

	// Writing 0 clears a flag, writing 1 leaves it alone.
	always_comb begin
		flagClr = 16'h0000;
		if (wrAccess && hitEvs) begin
			flagClr = ~pwdata[15:0] & EVS_MASK;
			flagClr[EVS_BREAK_BIT] = ~pwdata[EVS_BREAK_BIT] &
				~breakActive;
		end
	end

	assign next_eventStatus = ((eventStatus & ~flagClr) | flagSet) &
		EVS_MASK;

	// Requests toward the interrupt controller and the DMA engine.
	logic [6:0] dmaEvents;
	logic next_irq;

	assign dmaEvents = {next_trigEvent, switchEvent, chanEvent,
		updateEvent};
	assign next_irq = |(next_eventStatus[7:0] &
		irqDmaEnable[7:0]);

	// Register file; read data is caught in the setup phase so that it
	// comes from a flip-flop yet still answers with no wait state.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			slaveModeControl <= RST_SLAVE_MODE_CONTROL;
			irqDmaEnable <= RST_IRQ_DMA_ENABLE;
			eventStatus <= RST_EVENT_STATUS;
			prdata <= 32'h00000000;
		end else begin
			if (wrAccess && hitSmc) begin
				slaveModeControl <= pwdata[15:0] & SMC_MASK;
			end
			if (wrAccess && hitIde) begin
				irqDmaEnable <= pwdata[15:0] & IDE_MASK;
			end
			eventStatus <= next_eventStatus;
			if (rdSetup) begin
				prdata <= {16'h0000, readMux};
			end
		end
	end

	// Edge history and the dts divider.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			trigDelayed <= 1'b0;
			trigPrev <= 1'b0;
			etrfPrev <= 1'b0;
			in1Prev <= 1'b0;
			in2Prev <= 1'b0;
			dtsCount <= 2'h0;
		end else begin
			trigDelayed <= trigRaw;
			trigPrev <= slaveTriggerIn;
			etrfPrev <= extTrigFiltered;
			in1Prev <= in1Filtered;
			in2Prev <= in2Filtered;
			dtsCount <= dtsCount + 2'h1;
		end
	end

	// Registered controls toward the counter core and the system.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			countTick <= 1'b0;
			countDown <= 1'b0;
			counterReinit <= 1'b0;
			updateRequest <= 1'b0;
			countStart <= 1'b0;
			trigEvent <= 1'b0;
			irq <= 1'b0;
			dmaReq <= 7'h00;
		end else begin
			countTick <= next_countTick;
			if (isEncoder && encTick) begin
				countDown <= encDown;
			end
			counterReinit <= next_reinit;
			updateRequest <= next_reinit;
			countStart <= next_start;
			trigEvent <= next_trigEvent;
			irq <= next_irq;
			dmaReq <= dmaEvents &
				irqDmaEnable[IDE_DMA_LSB +: 7];
		end
	end

endmodule

/* File: logic/tsm_pkg.sv */
package tsm_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [7:0] OFS_SLAVE_MODE_CONTROL = 8'h08;
	localparam logic [7:0] OFS_IRQ_DMA_ENABLE = 8'h0c;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;

	// Values after reset.
	localparam logic [15:0] RST_SLAVE_MODE_CONTROL = 16'h0000;
	localparam logic [15:0] RST_IRQ_DMA_ENABLE = 16'h0000;
	localparam logic [15:0] RST_EVENT_STATUS = 16'h0000;

	// Implemented bits; everything else reads as zero.
	localparam logic [15:0] SMC_MASK = 16'hfff7;
	localparam logic [15:0] IDE_MASK = 16'h7fff;
	localparam logic [15:0] EVS_MASK = 16'h1eff;

	// Field positions in slave_mode_control.
	localparam int SMC_POL_BIT = 15;
	localparam int SMC_ECE_BIT = 14;
	localparam int SMC_PREDIV_LSB = 12;
	localparam int SMC_FILT_LSB = 8;
	localparam int SMC_MSM_BIT = 7;
	localparam int SMC_TS_LSB = 4;
	localparam int SMC_SMS_LSB = 0;

	// Field positions in irq_dma_enable and event_status.
	localparam int IDE_DMA_LSB = 8;
	localparam int EVS_UPDATE_BIT = 0;
	localparam int EVS_CHAN_LSB = 1;
	localparam int EVS_SWITCH_BIT = 5;
	localparam int EVS_TRIG_BIT = 6;
	localparam int EVS_BREAK_BIT = 7;
	localparam int EVS_OVC_LSB = 9;

	// Sibling timers that share the internal trigger ring, and channels per timer.
	localparam int NUM_TIMERS = 5;
	localparam int NUM_CHANNELS = 4;

	// Slave mode selection codes.
	typedef enum logic [2:0] {
		SMS_OFF = 3'h0,
		SMS_ENC1 = 3'h1,
		SMS_ENC2 = 3'h2,
		SMS_ENC3 = 3'h3,
		SMS_RESET = 3'h4,
		SMS_GATED = 3'h5,
		SMS_TRIGGER = 3'h6,
		SMS_EXTCLK1 = 3'h7
	} slave_mode_t;

	// Trigger source selection codes.
	typedef enum logic [2:0] {
		TS_INTERNAL_TRIG_0 = 3'h0,
		TS_ITR1 = 3'h1,
		TS_ITR2 = 3'h2,
		TS_ITR3 = 3'h3,
		TS_IN1_EDGE = 3'h4,
		TS_IN1 = 3'h5,
		TS_IN2 = 3'h6,
		TS_EXT = 3'h7
	} trig_src_t;

endpackage

/* File: logic/ext_trig_prescaler.sv */
`timescale 1ns/1ps

module ext_trig_prescaler
	import tsm_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic trigIn,
	input wire logic [1:0] prediv,
	output logic prescaled
);

	logic trigPrev;
	logic [2:0] edgeCount;
	logic risingEdge;
	logic next_prescaled;

	// A ripple of counter bits gives a square wave at 1/2, 1/4, 1/8.
	assign risingEdge = trigIn & ~trigPrev;
	assign next_prescaled = (prediv == 2'h0) ? trigIn :
		edgeCount[prediv - 2'h1];

	// Counting only rising edges keeps the ratio exact for any duty cycle.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			trigPrev <= 1'b0;
			edgeCount <= 3'h0;
			prescaled <= 1'b0;
		end else begin
			trigPrev <= trigIn;
			if (risingEdge) begin
				edgeCount <= edgeCount + 3'h1;
			end
			prescaled <= next_prescaled;
		end
	end

endmodule

/* File: logic/ext_trig_filter.sv */
`timescale 1ns/1ps

module ext_trig_filter
	import tsm_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sampleIn,
	input wire logic [3:0] code,
	input wire logic dtsTick,
	output logic filtered
);

	// Number of equal samples needed to accept a new level.
	function automatic logic [3:0] filt_len(input logic [3:0] c);
		logic [3:0] n;
		n = 4'h1;
		unique case (c)
			4'h0: n = 4'h1;
			4'h1: n = 4'h2;
			4'h2: n = 4'h4;
			4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: n = 4'h8;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
			4'ha, 4'hd: n = 4'h5;
		endcase
		return n;
	endfunction

	// Mask on the dts divider: all low bits zero marks a sample slot.
	function automatic logic [4:0] filt_mask(input logic [3:0] c);
		logic [4:0] m;
		m = 5'h00;
		if (c >= 4'hd) begin
			m = 5'h1f;
		end else if (c >= 4'ha) begin
			m = 5'h0f;
		end else if (c >= 4'h8) begin
			m = 5'h07;
		end else if (c >= 4'h6) begin
			m = 5'h03;
		end else if (c >= 4'h4) begin
			m = 5'h01;
		end
		return m;
	endfunction

	logic [4:0] dtsCount;
	logic [3:0] runLength;
	logic kernelRate;
	logic sampleEn;

	// Codes 1 to 3 sample every kernel cycle, the rest on dts slots.
	assign kernelRate = (code >= 4'h1) && (code <= 4'h3);
	assign sampleEn = kernelRate ||
		(dtsTick && ((dtsCount & filt_mask(code)) == 5'h00));

	// The run counter restarts whenever a sample agrees with the output.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dtsCount <= 5'h00;
			runLength <= 4'h0;
			filtered <= 1'b0;
		end else begin
			if (dtsTick) begin
				dtsCount <= dtsCount + 5'h01;
			end
			if (sampleEn) begin
				if (sampleIn == filtered) begin
					runLength <= 4'h0;
				end else if (runLength == filt_len(code) - 4'h1) begin
					filtered <= sampleIn;
					runLength <= 4'h0;
				end else begin
					runLength <= runLength + 4'h1;
				end
			end
		end
	end

endmodule

/* File: sim/timer_slave_chk.sv */
`timescale 1ns/1ps
// Watches the slave controller at its pins; the control registers are
// shadowed from bus writes because the checker cannot see inside.
module timer_slave_chk
	import tsm_pkg::*;
#(
	parameter int TIMER_INDEX = 0
)
(
	input logic mclk,
	input logic rstn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [NUM_TIMERS-1:0] siblingTrigOut,
	input logic in1EdgePulse,
	input logic in1Filtered,
	input logic in2Filtered,
	input logic countEnable,
	input logic updateEvent,
	input logic extTrigFiltered,
	input logic slaveTriggerIn,
	input logic countTick,
	input logic counterReinit,
	input logic updateRequest,
	input logic countStart,
	input logic trigEvent,
	input logic [6:0] dmaReq
);
	logic [15:0] smc;
	logic [15:0] ide;
	// Expected trigger source from the shadowed selection field.
	wire wr = psel && penable && pwrite;
	wire [2:0] slave_mode_sel = smc[2:0];
	wire [1:0] tsl = smc[5:4];
	wire [2:0] ring = 3'((TIMER_INDEX + int'(tsl) + 1) % NUM_TIMERS);
	wire srcSel = !smc[6] ? siblingTrigOut[ring] : tsl == 2'h0 ?
		in1EdgePulse : tsl == 2'h1 ? in1Filtered : tsl == 2'h2 ?
		in2Filtered : extTrigFiltered;

	// Shadows follow completed writes only.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			smc <= 16'h0000;
			ide <= 16'h0000;
		end else if (wr && paddr == OFS_SLAVE_MODE_CONTROL) begin
			smc <= pwdata[15:0];
		end else if (wr && paddr == OFS_IRQ_DMA_ENABLE) begin
			ide <= pwdata[15:0];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_src_select: assert property (
		!smc[7] |-> slaveTriggerIn == srcSel)
		else $error("trigger input not the selected source");
	a_sync_delay: assert property (
		smc[7] && $stable(smc) |-> slaveTriggerIn == $past(srcSel))
		else $error("synced trigger input lag wrong");
	a_reset_pulse: assert property (
		$rose(slaveTriggerIn) && slave_mode_sel == 3'h4 && $stable(smc)
		|=> counterReinit && updateRequest && trigEvent)
		else $error("reset mode pulses missing");
	a_trig_start: assert property (
		$rose(slaveTriggerIn) && slave_mode_sel == 3'h6 && $stable(smc) |=> countStart)
		else $error("trigger mode start missing");
	a_gate_stop: assert property (
		slave_mode_sel == 3'h5 && !smc[14] && !slaveTriggerIn && $stable(smc)
		|=> !countTick)
		else $error("gated counter ran with trigger low");
	a_gate_edges: assert property (
		slave_mode_sel == 3'h5 && $changed(slaveTriggerIn) && $stable(smc) |=> trigEvent)
		else $error("gated edge gave no trigger event");
	a_ext_clock: assert property (
		slave_mode_sel == 3'h7 && !smc[14] && countEnable && $rose(slaveTriggerIn)
		&& $stable(smc) |=> countTick)
		else $error("clock mode 1 edge gave no tick");
	a_trig_off: assert property (
		trigEvent |-> $past(slave_mode_sel) != 3'h0)
		else $error("trigger event with slave mode off");
	a_dma_trig: assert property (
		dmaReq[6] |-> trigEvent && $past(ide[14]))
		else $error("trigger dma request without cause");
	a_dma_update: assert property (
		dmaReq[0] |-> $past(updateEvent) && $past(ide[8]))
		else $error("update dma request without cause");
endmodule

/* File: sim/trig_partner.sv */
`timescale 1ns/1ps
// Sibling timer trigger outputs and the external trigger pin.
module trig_partner
	import tsm_pkg::*;
(
	input logic mclk,
	output logic extTriggerPin,
	output logic [NUM_TIMERS-1:0] siblingTrigOut
);
	// All sources idle low from time zero.
	initial begin
		extTriggerPin = 1'b0;
		siblingTrigOut = '0;
	end

	// Sibling j holds its trigger output high for w cycles.
	task automatic sib_pulse(input int j, input int w);
		@(posedge mclk);
		siblingTrigOut[j] <= 1'b1;
		repeat (w) @(posedge mclk);
		siblingTrigOut[j] <= 1'b0;
	endtask

	// Pin held at level v for w cycles.
	task automatic etr_level(input logic v, input int w);
		@(posedge mclk);
		extTriggerPin <= v;
		repeat (w - 1) @(posedge mclk);
	endtask

	// Clock train; short half periods are widened so the pin never
	// outruns a quarter of the timer clock.
	task automatic etr_train(input int n, input int half);
		int h;
		h = half < 2 ? 2 : half;
		repeat (n) begin
			etr_level(1'b1, h);
			etr_level(1'b0, h);
		end
	endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
	import tsm_pkg::*;
	localparam int IDX = 2;
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] clkDivSel;
	logic extTriggerPin, in1EdgePulse, in1Filtered, in2Filtered;
	logic [NUM_TIMERS-1:0] siblingTrigOut;
	logic countEnable, breakActive, updateEvent, switchEvent;
	logic [3:0] chanEvent, chanIsInput;
	logic countTick, countDown, counterReinit, updateRequest, countStart;
	logic trigEvent, extTrigFiltered, slaveTriggerIn, irq;
	logic [6:0] dmaReq;
	logic [7:0] ofs[3] = '{OFS_SLAVE_MODE_CONTROL, OFS_IRQ_DMA_ENABLE,
		OFS_EVENT_STATUS};
	logic [15:0] msk[3] = '{16'hfff7, 16'h7fff, 16'h0000};
	int fc[3] = '{3, 3, 1};
	int fw[3] = '{5, 12, 3};
	int fp[3] = '{0, 1, 1};
	int failCount = 0;
	int nTests = 0;
	int ticks = 0, reinits = 0, starts = 0, trigs = 0, fHigh = 0;
	int dmaT = 0, dmaU = 0;
	int s[4];
	int lat[2];

	timer_slave_ctrl #(.TIMER_INDEX(IDX)) DUT (.*);
	trig_partner P (.*);

	// Free-running timer clock.
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Pulses are counted on the falling edge, where outputs are settled.
	always @(negedge mclk) begin
		ticks += int'(countTick === 1'b1);
		reinits += int'(counterReinit === 1'b1);
		starts += int'(countStart === 1'b1);
		trigs += int'(trigEvent === 1'b1);
		fHigh += int'(extTrigFiltered === 1'b1);
		dmaT += int'(dmaReq[6] === 1'b1);
		dmaU += int'(dmaReq[0] === 1'b1);
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic closeOut();
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// One bus transfer; waits for pready, bounded by the watchdog.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic regchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("register", exp, rd);
	endtask

	task automatic smc_set(input logic [15:0] v);
		apb(1'b1, OFS_SLAVE_MODE_CONTROL, {16'h0, v});
	endtask

	// Raises the source that selection code ts picks, then drops it.
	task automatic fire(input int ts);
		if (ts < 4) begin
			P.sib_pulse((IDX + ts + 1) % NUM_TIMERS, 4);
		end else if (ts == 7) begin
			P.etr_level(1'b1, 6);
			P.etr_level(1'b0, 2);
		end else begin
			@(posedge mclk);
			in1EdgePulse <= ts == 4;
			in1Filtered <= ts == 5;
			in2Filtered <= ts == 6;
			@(posedge mclk);
			in1EdgePulse <= 1'b0;
			repeat (3) @(posedge mclk);
			in1Filtered <= 1'b0;
			in2Filtered <= 1'b0;
		end
	endtask

	task automatic strobe(input logic [5:0] v);
		@(posedge mclk);
		{switchEvent, updateEvent, chanEvent} <= v;
		@(posedge mclk);
		{switchEvent, updateEvent, chanEvent} <= '0;
	endtask

	// Hang guard, far beyond the thousand or so cycles the tests need.
	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		$display("FAIL watchdog expected finish seen hang");
		closeOut();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, clkDivSel} = '0;
		{in1EdgePulse, in1Filtered, in2Filtered, breakActive} = '0;
		{updateEvent, switchEvent, chanEvent} = '0;
		chanIsInput = 4'h1;
		countEnable = 1'b1;
		rstn = 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			regchk(ofs[i], 32'h0);
			apb(1'b1, ofs[i], 32'hffff_ffff);
			regchk(ofs[i], {16'h0, msk[i]});
			apb(1'b1, ofs[i], 32'h0);
		end
		apb(1'b0, 8'h04, 32'h0);
		check("hole error", 1, err);
		check("hole data", 0, rd);
		$display("test registers done");
		// Reset mode on every source; the timer's own output never counts.
		for (int ts = 0; ts < 8; ts++) begin
			smc_set(16'((ts << 4) | 4));
			s[0] = reinits;
			if (ts < 4) P.sib_pulse(IDX, 4);
			fire(ts);
			tick(4);
			check("reinit", 1, reinits - s[0]);
		end
		$display("test sources done");
		@(posedge mclk);
		countEnable <= 1'b0;
		for (int m = 4; m < 8; m++) begin
			smc_set(16'(16'h0050 | m));
			countEnable <= m[0];
			s = '{reinits, starts, ticks, trigs};
			fire(5);
			tick(4);
			check("reinit", m == 4, reinits - s[0]);
			check("start", m == 6, starts - s[1]);
			check("ticks", m == 5 ? 4 : m == 7, ticks - s[2]);
			check("trig", m == 5 ? 2 : 1, trigs - s[3]);
		end
		for (int k = 0; k < 2; k++) begin
			smc_set(16'h0054 | 16'(k << 7));
			@(posedge mclk);
			in1Filtered <= 1'b1;
			lat[k] = 0;
			do begin
				@(negedge mclk);
				lat[k]++;
			end while (counterReinit !== 1'b1 && lat[k] < 20);
			@(posedge mclk);
			in1Filtered <= 1'b0;
		end
		check("sync lag", 1, lat[1] - lat[0]);
		$display("test modes done");
		smc_set(16'h8000);
		tick(6);
		check("inverted", 1, extTrigFiltered);
		smc_set(16'h0000);
		tick(6);
		check("plain", 0, extTrigFiltered);
		for (int f = 0; f < 3; f++) begin
			smc_set(16'(fc[f] << 8));
			tick(12);
			s[0] = fHigh;
			P.etr_level(1'b1, fw[f]);
			P.etr_level(1'b0, 16);
			check("filter", fp[f], fHigh != s[0]);
		end
		// The ratio settles before mode 2 goes on; the last pass leaves
		// mode 2 off with clock mode 1 idle, so no tick may appear.
		for (int p = 0; p < 5; p++) begin
			smc_set(16'h0007 | 16'(p % 4 << 12));
			tick(4);
			if (p < 4) smc_set(16'h4007 | 16'(p << 12));
			s[2] = ticks;
			P.etr_train(16, 2);
			tick(12);
			check("etr ticks", p < 4 ? 16 >> p : 0, ticks - s[2]);
		end
		smc_set(16'h4077);
		s[2] = ticks;
		P.etr_train(4, 3);
		tick(12);
		check("both clocks", 4, ticks - s[2]);
		$display("test external done");
		smc_set(16'h0001);
		@(posedge mclk);
		in2Filtered <= 1'b1;
		tick(3);
		s[2] = ticks;
		@(posedge mclk);
		in1Filtered <= 1'b1;
		tick(3);
		check("enc down", 1, countDown);
		smc_set(16'h0002);
		@(posedge mclk);
		in1Filtered <= 1'b0;
		tick(3);
		@(posedge mclk);
		in2Filtered <= 1'b0;
		tick(3);
		check("enc up", 0, countDown);
		check("enc ticks", 2, ticks - s[2]);
		$display("test encoder done");
		apb(1'b1, OFS_EVENT_STATUS, 32'h0);
		apb(1'b1, OFS_IRQ_DMA_ENABLE, 32'h41ff);
		smc_set(16'h0056);
		fire(5);
		tick(3);
		check("irq", 1, irq);
		check("trig dma", 1, dmaT);
		regchk(OFS_EVENT_STATUS, 32'h0040);
		apb(1'b1, OFS_EVENT_STATUS, 32'h0);
		tick(2);
		check("irq", 0, irq);
		@(posedge mclk);
		breakActive <= 1'b1;
		tick(2);
		apb(1'b1, OFS_EVENT_STATUS, 32'h0);
		regchk(OFS_EVENT_STATUS, 32'h0080);
		@(posedge mclk);
		breakActive <= 1'b0;
		apb(1'b1, OFS_EVENT_STATUS, 32'h0);
		regchk(OFS_EVENT_STATUS, 32'h0);
		strobe(6'h01);
		strobe(6'h01);
		tick(2);
		regchk(OFS_EVENT_STATUS, 32'h0202);
		apb(1'b1, OFS_EVENT_STATUS, 32'h1dff);
		regchk(OFS_EVENT_STATUS, 32'h0002);
		strobe(6'h30);
		tick(2);
		regchk(OFS_EVENT_STATUS, 32'h0023);
		check("update dma", 1, dmaU);
		$display("test status done");
		closeOut();
	end
endmodule

bind timer_slave_ctrl timer_slave_chk #(.TIMER_INDEX(TIMER_INDEX)) chk (.*);
